/* File: core/exec_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module exec_timer
#(
   parameter int CNT_W = 4
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Start request
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] len,
   // Progress
   output var  logic [CNT_W-1:0] cnt_ff,
   output var  logic             last
);

   if (CNT_W < 2) begin : g_bad_width
      $error("exec_timer needs CNT_W of at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Down counter, one step per cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
      end else if (start) begin
         cnt_ff <= len;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   // Final busy cycle
   assign last = (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   start_load_a: assert property (start |=> cnt_ff == $past(len))
      else $error("timer did not load the cycle count");
   count_step_a: assert property (!start && cnt_ff != '0 |=> cnt_ff == $past(cnt_ff) - 1'b1)
      else $error("timer did not step down by one");

endmodule : exec_timer

`default_nettype wire

/* File: core/program_system_control_decoder.sv */
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Call pushes PC+1, loads page and operand
// - Jump loads nine bits plus page, no push
// - Plain return pops PC, status untouched
// - Paged return also copies stacked page bits
// - Interrupt return restores shadows, keeps timeout/powerdown
// - Variant interrupt return adds W to counter
// - Literal return loads W and pops PC
// - Bank select sets pointer bits 7:5, one cycle
// - Program read replaces mode:W with memory word
// - Page select writes status bits 7:5, one cycle
// - Sleep clears watchdog, prescaler if assigned, sets timeout, clears powerdown, stops
// - W into file 02 jumps, 4/3 cycles
// - Bit test skip takes 1 or 2 cycles, except a taken skip on PC bit 0
// - Skip on PC bit 0 takes 4/2 cycles
// - Carry bit 0, zero bit 2 of file 03
// - Immediate into mode register takes one cycle
module program_system_control_decoder
   import psc_pkg::*;
#(
   parameter int STACK_DEPTH = 8
)
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Instruction memory read port
   output var  logic [11:0] imem_addr,
   input  wire logic [11:0] imem_rdata,
   // System side effects
   output var  logic        watchdog_clear,
   output var  logic        prescaler_clear,
   output var  logic        osc_stop
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   if ((STACK_DEPTH < 2) || ((STACK_DEPTH & (STACK_DEPTH - 1)) != 0)) begin : g_bad_depth
      $error("STACK_DEPTH must be a power of two of at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State
   core_state_t     state_ff;
   core_state_t     nxt_state;
   logic [7:0]      w_ff;
   logic [7:0]      status_ff;
   logic [7:0]      data_bank_pointer_ff;
   logic [7:0]      realtime_counter_ff;
   logic [3:0]      mode_ff;
   logic [PC_W-1:0] pc_ff;
   logic [7:0]      sh_w_ff;
   logic [7:0]      sh_status_ff;
   logic [7:0]      sh_bank_ff;
   logic [PC_W-1:0] sh_pc_ff;
   logic            turbo_ff;
   logic            presc_assigned_ff;
   logic            program_memory_read_op_pend_ff;
   logic [PC_W-1:0] stack_ff [STACK_DEPTH];
   logic [SP_W-1:0] sp_ff;
   logic [3:0]      tmr_cnt;
   logic            tmr_last;

   // Decode results
   logic [7:0]      nxt_w;
   logic [7:0]      nxt_status;
   logic [7:0]      nxt_bank;
   logic [7:0]      nxt_rtc;
   logic [3:0]      nxt_mode;
   logic [PC_W-1:0] nxt_pc;
   logic [3:0]      cyc;
   logic            do_push;
   logic            do_pop;
   logic            do_sleep;
   logic            do_program_memory_read_op;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [3:0] pick(input logic turbo, input logic [3:0] c,
                                       input logic [3:0] t);
      pick = turbo ? t : c;
   endfunction : pick

   function automatic logic [7:0] read_file(input logic [4:0] fa, input logic [7:0] pcl,
                                            input logic [7:0] st, input logic [7:0] bank);
      unique case (fa)
         F_PC:     read_file = pcl;
         F_STATUS: read_file = st;
         F_BANK:   read_file = bank;
         default:  read_file = 8'h00;
      endcase
   endfunction : read_file

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= A_SH_PC) && (a[1:0] == 2'b00);
   endfunction : is_mapped

   ////////////////////////////////////////////////////////////////////////////
   // APB handshake, one wait state
   logic            acc;
   logic            wr;
   logic            issue;
   logic [11:0]     op;
   logic [PC_W-1:0] tos;
   logic [PC_W-1:0] pc_inc;

   assign acc    = psel && penable && pready;
   assign wr     = acc && pwrite;
   assign issue  = wr && (paddr == A_INSTR) && (state_ff == S_IDLE);
   assign op     = pwdata[OP_W-1:0];
   assign tos    = stack_ff[sp_ff - 1'b1];
   assign pc_inc = pc_ff + 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // Read data and error, valid with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pslverr <= !is_mapped(paddr);
         prdata  <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               A_CTRL:      prdata <= {30'h0, presc_assigned_ff, turbo_ff};
               A_STATE:     prdata <= {16'h0, 8'(sp_ff), tmr_cnt, 1'b0, program_memory_read_op_pend_ff, state_ff};
               A_WREG:      prdata <= {24'h0, w_ff};
               A_STATUS:    prdata <= {24'h0, status_ff};
               A_BANK:      prdata <= {24'h0, data_bank_pointer_ff};
               A_PC:        prdata <= {21'h0, pc_ff};
               A_MODE:      prdata <= {28'h0, mode_ff};
               A_RTC:       prdata <= {24'h0, realtime_counter_ff};
               A_TOS:       prdata <= {21'h0, tos};
               A_SH_WREG:   prdata <= {24'h0, sh_w_ff};
               A_SH_STATUS: prdata <= {24'h0, sh_status_ff};
               A_SH_BANK:   prdata <= {24'h0, sh_bank_ff};
               A_SH_PC:     prdata <= {21'h0, sh_pc_ff};
               default:     prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode and execute
   always_comb begin
      logic [4:0] fa;
      logic [2:0] bsel;
      logic [7:0] fval;
      logic [8:0] sum;
      fa         = op[4:0];
      bsel       = op[7:5];
      fval       = read_file(fa, pc_ff[7:0], status_ff, data_bank_pointer_ff);
      sum        = {1'b0, fval} + {1'b0, w_ff};
      nxt_w      = w_ff;
      nxt_status = status_ff;
      nxt_bank   = data_bank_pointer_ff;
      nxt_rtc    = realtime_counter_ff;
      nxt_mode   = mode_ff;
      nxt_pc     = pc_inc;
      cyc        = CYC_SINGLE;
      do_push    = 1'b0;
      do_pop     = 1'b0;
      do_sleep   = 1'b0;
      do_program_memory_read_op   = 1'b0;
      if (op[11:8] == PFX_CALL) begin
         do_push = 1'b1;
         nxt_pc  = {status_ff[6:5], 1'b0, op[7:0]};
         cyc     = pick(turbo_ff, CYC_BRANCH_COMPAT, CYC_BRANCH_TURBO);
      end else if (op[11:9] == PFX_BRANCH) begin
         nxt_pc = {status_ff[6:5], op[8:0]};
         cyc    = pick(turbo_ff, CYC_BRANCH_COMPAT, CYC_BRANCH_TURBO);
      end else if (op[11:8] == PFX_LIT_RETURN) begin
         nxt_w  = op[7:0];
         nxt_pc = tos;
         do_pop = 1'b1;
         cyc    = pick(turbo_ff, CYC_BRANCH_COMPAT, CYC_BRANCH_TURBO);
      end else if (op == OP_PLAIN_RETURN || op == OP_PAGED_RETURN) begin
         nxt_pc = tos;
         do_pop = 1'b1;
         cyc    = pick(turbo_ff, CYC_BRANCH_COMPAT, CYC_BRANCH_TURBO);
         if (op == OP_PAGED_RETURN) begin
            nxt_status[6:5] = tos[10:9];
         end
      end else if (op == OP_INTERRUPT_RETURN || op == OP_INTERRUPT_RET_ADD) begin
         nxt_w      = sh_w_ff;
         nxt_status = {sh_status_ff[7:5], status_ff[4:3], sh_status_ff[2:0]};
         nxt_bank   = sh_bank_ff;
         nxt_pc     = sh_pc_ff;
         cyc        = pick(turbo_ff, CYC_BRANCH_COMPAT, CYC_BRANCH_TURBO);
         if (op == OP_INTERRUPT_RET_ADD) begin
            nxt_rtc = realtime_counter_ff + w_ff;
         end
      end else if (op[11:3] == PFX_BANK_SEL) begin
         nxt_bank[7:5] = op[2:0];
      end else if (op[11:3] == PFX_PAGE_SEL) begin
         nxt_status[7:5] = op[2:0];
      end else if (op == OP_PROGRAM_MEM_READ) begin
         do_program_memory_read_op = 1'b1;
         cyc      = pick(turbo_ff, CYC_PROGRAM_MEMORY_READ_OP_COMPAT, CYC_PROGRAM_MEMORY_READ_OP_TURBO);
      end else if (op == OP_SLEEP) begin
         do_sleep              = 1'b1;
         nxt_status[BIT_TMOUT] = 1'b1;
         nxt_status[BIT_PWRDN] = 1'b0;
      end else if (op[11:4] == PFX_MODE_IMM) begin
         nxt_mode = op[3:0];
      end else if (op[11:5] == PFX_MOVE_FILE) begin
         if (fa == F_PC) begin
            nxt_pc = {status_ff[6:5], 1'b0, w_ff};
            cyc    = pick(turbo_ff, CYC_PCWR_COMPAT, CYC_PCWR_TURBO);
         end else if (fa == F_STATUS) begin
            nxt_status = w_ff;
         end else if (fa == F_BANK) begin
            nxt_bank = w_ff;
         end
      end else if (op[11:5] == PFX_ADD_FILE) begin
         if (fa == F_PC) begin
            nxt_pc = {status_ff[6:5], 1'b0, pc_inc[7:0] + w_ff};
            cyc    = pick(turbo_ff, CYC_PCWR_COMPAT, CYC_PCWR_TURBO);
         end else begin
            if (fa == F_STATUS) begin
               nxt_status = sum[7:0];
            end else if (fa == F_BANK) begin
               nxt_bank = sum[7:0];
            end
            nxt_status[BIT_CARRY] = sum[8];
            nxt_status[BIT_ZERO]  = (sum[7:0] == 8'h00);
         end
      end else if (op[11:9] == PFX_BIT_WRITE) begin
         fval[bsel] = op[8];
         if (fa == F_STATUS) begin
            nxt_status = fval;
         end else if (fa == F_BANK) begin
            nxt_bank = fval;
         end
      end else if (op[11:9] == PFX_BIT_TEST) begin
         if (fval[bsel] == op[8]) begin
            nxt_pc = pc_ff + 11'h002;
            cyc    = CYC_SKIP;
            if (fa == F_PC && bsel == 3'h0) begin
               cyc = pick(turbo_ff, CYC_PCSKIP_COMPAT, CYC_PCSKIP_TURBO);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Working register and mode, also loaded by program read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_ff    <= 8'h00;
         mode_ff <= RST_MODE;
      end else if (issue) begin
         w_ff    <= nxt_w;
         mode_ff <= nxt_mode;
      end else if (program_memory_read_op_pend_ff) begin
         w_ff    <= imem_rdata[7:0];
         mode_ff <= imem_rdata[11:8];
      end else if (wr && paddr == A_WREG) begin
         w_ff <= pwdata[7:0];
      end else if (wr && paddr == A_MODE) begin
         mode_ff <= pwdata[3:0];
      end
   end

   // Status, bank pointer, counter, program counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff            <= RST_STATUS;
         data_bank_pointer_ff <= 8'h00;
         realtime_counter_ff  <= 8'h00;
         pc_ff                <= RST_PC;
      end else if (issue) begin
         status_ff            <= nxt_status;
         data_bank_pointer_ff <= nxt_bank;
         realtime_counter_ff  <= nxt_rtc;
         pc_ff                <= nxt_pc;
      end else if (wr) begin
         if (paddr == A_STATUS) status_ff <= pwdata[7:0];
         if (paddr == A_BANK) data_bank_pointer_ff <= pwdata[7:0];
         if (paddr == A_RTC) realtime_counter_ff <= pwdata[7:0];
         if (paddr == A_PC) pc_ff <= pwdata[PC_W-1:0];
      end
   end

   // Shadow copies and control, software loaded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_w_ff           <= 8'h00;
         sh_status_ff      <= 8'h00;
         sh_bank_ff        <= 8'h00;
         sh_pc_ff          <= RST_PC;
         turbo_ff          <= 1'b0;
         presc_assigned_ff <= 1'b0;
      end else if (wr) begin
         if (paddr == A_SH_WREG) sh_w_ff <= pwdata[7:0];
         if (paddr == A_SH_STATUS) sh_status_ff <= pwdata[7:0];
         if (paddr == A_SH_BANK) sh_bank_ff <= pwdata[7:0];
         if (paddr == A_SH_PC) sh_pc_ff <= pwdata[PC_W-1:0];
         if (paddr == A_CTRL) begin
            turbo_ff          <= pwdata[CTRL_TURBO];
            presc_assigned_ff <= pwdata[CTRL_PRESC];
         end
      end
   end

   // Return stack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_ff <= '0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_ff[i] <= RST_PC;
         end
      end else if (issue && do_push) begin
         stack_ff[sp_ff] <= pc_inc;
         sp_ff           <= sp_ff + 1'b1;
      end else if (issue && do_pop) begin
         sp_ff <= sp_ff - 1'b1;
      end
   end

   // Program memory fetch address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imem_addr     <= 12'h000;
         program_memory_read_op_pend_ff <= 1'b0;
      end else begin
         program_memory_read_op_pend_ff <= issue && do_program_memory_read_op;
         if (issue && do_program_memory_read_op) imem_addr <= {mode_ff, w_ff};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core state machine
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE:  if (issue) nxt_state = do_sleep ? S_SLEEP : S_EXEC;
         S_EXEC:  if (tmr_last) nxt_state = S_IDLE;
         S_SLEEP: if (wr && paddr == A_CTRL && pwdata[CTRL_WAKE]) nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= S_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Sleep side effects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_clear  <= 1'b0;
         prescaler_clear <= 1'b0;
         osc_stop        <= 1'b0;
      end else begin
         watchdog_clear  <= issue && do_sleep;
         prescaler_clear <= issue && do_sleep && presc_assigned_ff;
         osc_stop        <= (nxt_state == S_SLEEP);
      end
   end

   // Instruction cycle counter
   exec_timer #(.CNT_W(4)) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (issue && !do_sleep),
      .len     (cyc),
      .cnt_ff  (tmr_cnt),
      .last    (tmr_last)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   call_push_a: assert property (issue && op[11:8] == PFX_CALL |=>
      sp_ff == SP_W'($past(sp_ff) + 1'b1) && tos == $past(pc_inc) && pc_ff[8] == 1'b0)
      else $error("call did not push and load");
   jump_load_a: assert property (issue && op[11:9] == PFX_BRANCH |=>
      pc_ff == {$past(status_ff[6:5]), $past(op[8:0])} && $stable(sp_ff))
      else $error("jump target or stack wrong");
   ret_keep_a: assert property (issue && op == OP_PLAIN_RETURN |=>
      pc_ff == $past(tos) && $stable(status_ff))
      else $error("plain return wrong");
   paged_ret_a: assert property (issue && op == OP_PAGED_RETURN |=>
      status_ff[6:5] == $past(tos[10:9]))
      else $error("paged return page bits wrong");
   interrupt_return_op_flags_a: assert property (issue && op[11:1] == OP_INTERRUPT_RETURN[11:1] |=>
      status_ff[4:3] == $past(status_ff[4:3]) && w_ff == $past(sh_w_ff) && pc_ff == $past(sh_pc_ff))
      else $error("interrupt return restore wrong");
   interrupt_return_add_op_add_a: assert property (issue && op == OP_INTERRUPT_RET_ADD |=>
      realtime_counter_ff == 8'($past(realtime_counter_ff) + $past(w_ff)))
      else $error("counter not advanced by W");
   bank_one_a: assert property (issue && op[11:3] == PFX_BANK_SEL |=>
      data_bank_pointer_ff[7:5] == $past(op[2:0]) && state_ff == S_EXEC ##1 state_ff == S_IDLE)
      else $error("bank select not one cycle");
   pcwr_compat_a: assert property (issue && op[11:5] == PFX_MOVE_FILE && op[4:0] == F_PC
      && !turbo_ff |=> (state_ff == S_EXEC) [*4] ##1 state_ff == S_IDLE)
      else $error("indirect jump not four cycles");
   sleep_entry_a: assert property (issue && op == OP_SLEEP |=>
      watchdog_clear && osc_stop && status_ff[BIT_TMOUT] && !status_ff[BIT_PWRDN])
      else $error("sleep entry effects missing");
   call_turbo_a: assert property (issue && op[11:8] == PFX_CALL && turbo_ff |=>
      (state_ff == S_EXEC) [*3] ##1 state_ff == S_IDLE)
      else $error("call not three turbo cycles");
   program_memory_read_op_turbo_a: assert property (issue && op == OP_PROGRAM_MEM_READ && turbo_ff |=>
      (state_ff == S_EXEC) [*4] ##1 state_ff == S_IDLE)
      else $error("program read not four turbo cycles");
   pcadd_turbo_a: assert property (issue && op[11:5] == PFX_ADD_FILE
      && op[4:0] == F_PC && turbo_ff
      |=> (state_ff == S_EXEC) [*3] ##1 state_ff == S_IDLE)
      else $error("relative jump not three turbo cycles");
   skip_taken_a: assert property (issue && op[11:9] == PFX_BIT_TEST
      && op[4:0] == F_STATUS && status_ff[op[7:5]] == op[8]
      |=> (state_ff == S_EXEC) [*2] ##1 state_ff == S_IDLE)
      else $error("taken skip not two cycles");
   skip_fall_a: assert property (issue && op[11:9] == PFX_BIT_TEST
      && op[4:0] == F_STATUS && status_ff[op[7:5]] != op[8]
      |=> state_ff == S_EXEC ##1 state_ff == S_IDLE)
      else $error("untaken skip not one cycle");
   pcskip_compat_a: assert property (issue && op[11:9] == PFX_BIT_TEST
      && op[7:0] == {3'h0, F_PC} && pc_ff[0] == op[8] && !turbo_ff
      |=> (state_ff == S_EXEC) [*4] ##1 state_ff == S_IDLE)
      else $error("counter skip not four cycles");
   pcskip_turbo_a: assert property (issue && op[11:9] == PFX_BIT_TEST
      && op[7:0] == {3'h0, F_PC} && pc_ff[0] == op[8] && turbo_ff
      |=> (state_ff == S_EXEC) [*2] ##1 state_ff == S_IDLE)
      else $error("counter skip not two turbo cycles");

   cover_interrupt_return_add_op_c: cover property (issue && op == OP_INTERRUPT_RET_ADD);
   cover_skip_c:  cover property (issue && op[11:9] == PFX_BIT_TEST && cyc != CYC_SINGLE);
   cover_wake_c:  cover property (state_ff == S_SLEEP ##[1:20] state_ff == S_IDLE);

endmodule : program_system_control_decoder

`default_nettype wire

/* File: core/psc_pkg.sv */
package psc_pkg;

   // Widths
   localparam int OP_W = 12;
   localparam int PC_W = 11;

   // Register byte offsets
   localparam logic [7:0] A_INSTR     = 8'h00;
   localparam logic [7:0] A_CTRL      = 8'h04;
   localparam logic [7:0] A_STATE     = 8'h08;
   localparam logic [7:0] A_WREG      = 8'h0C;
   localparam logic [7:0] A_STATUS    = 8'h10;
   localparam logic [7:0] A_BANK      = 8'h14;
   localparam logic [7:0] A_PC        = 8'h18;
   localparam logic [7:0] A_MODE      = 8'h1C;
   localparam logic [7:0] A_RTC       = 8'h20;
   localparam logic [7:0] A_TOS       = 8'h24;
   localparam logic [7:0] A_SH_WREG   = 8'h28;
   localparam logic [7:0] A_SH_STATUS = 8'h2C;
   localparam logic [7:0] A_SH_BANK   = 8'h30;
   localparam logic [7:0] A_SH_PC     = 8'h34;

   // Control register bits
   localparam int CTRL_TURBO = 0;
   localparam int CTRL_PRESC = 1;
   localparam int CTRL_WAKE  = 2;

   // File addresses
   localparam logic [4:0] F_PC     = 5'h02;
   localparam logic [4:0] F_STATUS = 5'h03;
   localparam logic [4:0] F_BANK   = 5'h04;

   // Status bit positions
   localparam int BIT_CARRY = 0;
   localparam int BIT_ZERO  = 2;
   localparam int BIT_PWRDN = 3;
   localparam int BIT_TMOUT = 4;

   // Full opcodes
   localparam logic [11:0] OP_PLAIN_RETURN      = 12'h00C;
   localparam logic [11:0] OP_PAGED_RETURN      = 12'h00D;
   localparam logic [11:0] OP_INTERRUPT_RETURN  = 12'h00E;
   localparam logic [11:0] OP_INTERRUPT_RET_ADD = 12'h00F;
   localparam logic [11:0] OP_SLEEP             = 12'h003;
   localparam logic [11:0] OP_PROGRAM_MEM_READ  = 12'h041;

   // Opcode prefixes
   localparam logic [3:0] PFX_CALL        = 4'h9;
   localparam logic [3:0] PFX_LIT_RETURN  = 4'h8;
   localparam logic [2:0] PFX_BRANCH      = 3'h5;
   localparam logic [8:0] PFX_BANK_SEL    = 9'h003;
   localparam logic [8:0] PFX_PAGE_SEL    = 9'h002;
   localparam logic [7:0] PFX_MODE_IMM    = 8'h05;
   localparam logic [6:0] PFX_MOVE_FILE   = 7'h01;
   localparam logic [6:0] PFX_ADD_FILE    = 7'h0F;
   localparam logic [2:0] PFX_BIT_WRITE   = 3'h2;
   localparam logic [2:0] PFX_BIT_TEST    = 3'h3;

   // Cycle counts, compatible and turbo
   localparam logic [3:0] CYC_SINGLE        = 4'h1;
   localparam logic [3:0] CYC_SKIP          = 4'h2;
   localparam logic [3:0] CYC_BRANCH_COMPAT = 4'h2;
   localparam logic [3:0] CYC_BRANCH_TURBO  = 4'h3;
   localparam logic [3:0] CYC_PROGRAM_MEMORY_READ_OP_COMPAT  = 4'h1;
   localparam logic [3:0] CYC_PROGRAM_MEMORY_READ_OP_TURBO   = 4'h4;
   localparam logic [3:0] CYC_PCWR_COMPAT   = 4'h4;
   localparam logic [3:0] CYC_PCWR_TURBO    = 4'h3;
   localparam logic [3:0] CYC_PCSKIP_COMPAT = 4'h4;
   localparam logic [3:0] CYC_PCSKIP_TURBO  = 4'h2;

   // Reset values
   localparam logic [7:0]  RST_STATUS = 8'h18;
   localparam logic [10:0] RST_PC     = 11'h000;
   localparam logic [3:0]  RST_MODE   = 4'h0;

   // Core states
   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_EXEC  = 2'b01,
      S_SLEEP = 2'b10
   } core_state_t;

endpackage : psc_pkg

/* File: dv/program_system_control_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module program_system_control_decoder_tb;
   import psc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wdc, psc, osc_stop;
   logic [7:0]  paddr, lit;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] imem_addr, imem_rdata;
   logic [32:0] q_d[$], q_m[$];
   int          fail_count = 0, compares = 0, cyc = 0, wd_n = 0, ps_n = 0;
   program_system_control_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .imem_addr(imem_addr), .imem_rdata(imem_rdata),
      .watchdog_clear(wdc), .prescaler_clear(psc), .osc_stop(osc_stop));
   // Memory model returns inverted address
   assign imem_rdata = ~imem_addr;
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
      compares++;
      if ((got & m) !== (exp & m)) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Read monitor takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && q_d.size() > 0)
         cmp({pslverr, prdata}, q_d.pop_front(), q_m.pop_front());
   end
   // Pulse counters and timeout
   always @(posedge pclk) begin
      cyc++;
      if (wdc === 1'b1) wd_n++;
      if (psc === 1'b1) ps_n++;
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic chk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF, input logic err = 1'b0);
      q_d.push_back({err, e});
      q_m.push_back({1'b1, m});
      apb(1'b0, a, 32'h0);
   endtask : chk
   // Issue one opcode and wait until idle
   task automatic op(input logic [11:0] i);
      wr(A_INSTR, {20'h0, i});
      do chk(A_STATE, 32'h0, 32'h0); while (rd[1:0] !== 2'b00);
   endtask : op
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
      presetn = 1'b0;
      void'($urandom(32'hBFC5190C));
      lit = 8'($urandom());
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk(A_STATUS, 32'h18); chk(A_PC, 32'h0); chk(A_MODE, 32'h0);
      op(12'h015); chk(A_STATUS, 32'hB8);
      wr(A_PC, 32'h10); op(12'h9AB);
      chk(A_PC, 32'h2AB); chk(A_TOS, 32'h11);
      op(12'hB5A); chk(A_PC, 32'h35A); chk(A_TOS, 32'h11);
      op({4'h8, lit}); chk(A_WREG, {24'h0, lit}); chk(A_PC, 32'h11);
      $display("branch test done");
      wr(A_PC, 32'h5F0); op(12'h9AB); op(12'h00D);
      chk(A_PC, 32'h5F1); chk(A_STATUS, 32'hD8);
      op(12'h9AB); op(12'h00C); chk(A_PC, 32'h5F2); chk(A_STATUS, 32'hD8);
      op(12'h01E); chk(A_BANK, 32'hC0);
      $display("return test done");
      wr(A_WREG, 32'h10); wr(A_RTC, 32'h20); wr(A_SH_WREG, 32'h5A);
      wr(A_SH_STATUS, 32'h0F); wr(A_SH_BANK, 32'h33); wr(A_SH_PC, 32'h123);
      op(12'h00F); chk(A_RTC, 32'h30);
      chk(A_WREG, 32'h5A); chk(A_STATUS, 32'h1F); chk(A_BANK, 32'h33);
      wr(A_STATUS, 32'h0); wr(A_WREG, 32'h77); op(12'h00E);
      chk(A_WREG, 32'h5A); chk(A_STATUS, 32'h07); chk(A_RTC, 32'h30);
      $display("interrupt return test done");
      op(12'h053); chk(A_MODE, 32'h3);
      wr(A_WREG, {24'h0, ~lit}); op(12'h041);
      chk(A_MODE, 32'hC); chk(A_WREG, {24'h0, lit});
      wr(A_STATUS, 32'h05); op(12'h403); chk(A_STATUS, 32'h04);
      op(12'h443); chk(A_STATUS, 32'h00);
      wr(A_PC, 32'h100); op(12'h703); chk(A_PC, 32'h101);
      op(12'h603); chk(A_PC, 32'h103);
      op(12'h702); chk(A_PC, 32'h105);
      wr(A_STATUS, 32'h40); wr(A_WREG, 32'h37); op(12'h022); chk(A_PC, 32'h437);
      wr(A_CTRL, 32'h1); op(12'h1E2); chk(A_PC, 32'h46F);
      op(12'h702); chk(A_PC, 32'h471);
      op(12'h9AB); chk(A_PC, 32'h4AB); chk(A_TOS, 32'h472);
      op(12'h041); chk(A_MODE, 32'h3); chk(A_WREG, 32'hC8);
      $display("system test done");
      wr(A_CTRL, 32'h2); wr(A_INSTR, {20'h0, OP_SLEEP});
      chk(A_STATE, 32'h2, 32'h3); chk(A_STATUS, 32'h50);
      cmp({32'h0, osc_stop}, 33'h1, 33'h1);
      cmp(33'(wd_n), 33'h1, 33'hFF); cmp(33'(ps_n), 33'h1, 33'hFF);
      wr(A_CTRL, 32'h4); chk(A_STATE, 32'h0, 32'h3);
      cmp({32'h0, osc_stop}, 33'h0, 33'h1);
      wr(A_INSTR, {20'h0, OP_SLEEP}); wr(A_CTRL, 32'h4);
      cmp(33'(wd_n), 33'h2, 33'hFF); cmp(33'(ps_n), 33'h1, 33'hFF);
      chk(8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
      $display("sleep and error test done");
      test_done();
   end
endmodule : program_system_control_decoder_tb
`default_nettype wire
